// [verilog/pcg_top.sv]
// pcg_top: apb register file, module enables, bus and crystal clock
// gating, master clock forwarding and codec register forwarding.
// assumes an apb3 master on pclk; crystal_clock_in is asynchronous.
`timescale 1ns/1ps
`default_nettype none
// Function
// - power and gating change only through software register writes.
// - registers keep contents through any gated or powered-down state.
// - control bits 6..2 at 00h enable joystick, midi port, serial audio.
// - serial audio has three enables: two playback, one record channel.
// - modules without an enable bit stay running regardless of enables.
// - bus clock gated: bus interface and irq/select keep their clock.
// - crystal gated: every internal user and master clock out stop.
// - after reset the device sleeps with all modules disabled.
// - master clock to the codec is a buffered copy of the crystal input; here it is the crystal resampled on pclk after the sync flops.
module pcg_top
    import pcg_pkg::*;
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [pcg_pkg::ADDR_W-1:0] paddr,
    input  wire logic [pcg_pkg::DATA_W-1:0] pwdata,
    output var  logic [pcg_pkg::DATA_W-1:0] prdata,
    output var  logic                    pready,
    output var  logic                    pslverr,
    input  wire logic                    crystal_clock_in,
    output var  logic                    buffered_master_clock_out,
    output var  logic                    xtal_clk_en,
    output var  logic                    core_clk_en,
    output var  logic                    bus_if_clk_en,
    output var  logic                    joy_run,
    output var  logic                    uart_run,
    output var  logic                    dac1_run,
    output var  logic                    dac2_run,
    output var  logic                    adc_run,
    output var  logic                    codec_wr_valid,
    input  wire logic                    codec_wr_ready,
    output var  logic [6:0]              codec_wr_index,
    output var  logic [15:0]             codec_wr_data
);
    import pcg_pkg::*;

    // register state
    logic [4:0]  ctrl_en_r;
    logic [4:0]  ctrl_en_nxt;
    logic [1:0]  pmctl_r;
    logic [1:0]  pmctl_nxt;
    logic        codec_pd_r;
    logic        codec_pd_nxt;
    logic [6:0]  cx_idx_r;
    logic [6:0]  cx_idx_nxt;
    logic [15:0] cx_data_r;
    logic [15:0] cx_data_nxt;
    logic        cx_valid_r;
    logic        cx_valid_nxt;

    // bus interface
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        pready_r;
    logic        pslverr_r;
    logic        pslverr_nxt;
    logic        presetn_q_r;

    // clock side
    logic        xtal_s1_r;
    logic        xtal_s2_r;
    logic        xtal_s3_r;
    logic        bus_run;
    logic        xtal_run;
    logic        mclk_r;
    logic        mclk_nxt;
    logic        xtal_en_r;
    logic        xtal_en_nxt;
    logic [4:0]  run_r;
    logic [4:0]  run_nxt;

    // decode
    wire         setup_w   = psel & ~penable;
    wire         access_w  = psel & penable & pready_r;
    wire         wr_w      = access_w & pwrite;
    wire         hit_ctrl  = (paddr == ADDR_CTRL);
    wire         hit_pm    = (paddr == ADDR_PMCTL);
    wire         hit_stat  = (paddr == ADDR_STATUS);
    wire         hit_codec = (paddr == ADDR_CODEC);
    wire         mapped_w  = hit_ctrl | hit_pm | hit_stat | hit_codec;
    // status is read-only: writing it is flagged
    wire         bad_w     = ~mapped_w | (pwrite & hit_stat);
    wire         cx_wr_w   = wr_w & hit_codec & ~cx_valid_r;
    wire         cx_done_w = cx_valid_r & codec_wr_ready;
    wire [6:0]   wr_idx_w  = pwdata[CX_IDX_HI:CX_IDX_LO];
    wire [15:0]  wr_data_w = pwdata[CX_DATA_HI:CX_DATA_LO];

    // write paths; only software writes move any of this state
    assign ctrl_en_nxt = (wr_w & hit_ctrl) ?
                         pwdata[EN_HI:EN_LO] : ctrl_en_r;
    assign pmctl_nxt   = (wr_w & hit_pm) ?
                         pwdata[1:0] : pmctl_r;

    // codec forwarding; a write while busy is dropped, not queued
    assign cx_idx_nxt   = cx_wr_w ? wr_idx_w : cx_idx_r;
    assign cx_data_nxt  = cx_wr_w ? wr_data_w : cx_data_r;
    assign cx_valid_nxt = cx_wr_w | (cx_valid_r & ~codec_wr_ready);

    // track codec power state from the forwarded write
    wire   pd_hit_w     = cx_done_w & (cx_idx_r == CODEC_PD_INDEX);
    assign codec_pd_nxt = pd_hit_w ?
                          ~cx_data_r[CODEC_PD_BIT] : codec_pd_r;

    // read mux
    wire [31:0] rd_ctrl  = {25'h0, ctrl_en_r, 2'h0};
    wire [31:0] rd_pm    = {30'h0, pmctl_r};
    wire [31:0] rd_stat  = {23'h0, cx_valid_r, codec_pd_r, run_r,
                            xtal_run, bus_run};
    wire [31:0] rd_codec = {9'h0, cx_idx_r, cx_data_r};
    assign prdata_nxt = ~(setup_w & ~pwrite) ? prdata_r :
                        hit_ctrl  ? rd_ctrl  :
                        hit_pm    ? rd_pm    :
                        hit_stat  ? rd_stat  :
                        hit_codec ? rd_codec : 32'h0000_0000;
    assign pslverr_nxt = setup_w ? bad_w : pslverr_r;

    // crystal: two-flop sync then a third for edge detect
    pcg_gate_cell u_gate_xtal (
        .clk       (pclk),
        .rst_n     (presetn),
        .run_req   (pmctl_r[PM_XTAL_RUN_BIT]),
        .phase_low (~xtal_s2_r),
        .run_r     (xtal_run)
    );

    // bus clock enable gate; pclk domain has no low phase to wait for
    pcg_gate_cell u_gate_bus (
        .clk       (pclk),
        .rst_n     (presetn),
        .run_req   (pmctl_r[PM_BUS_RUN_BIT]),
        .phase_low (1'b1),
        .run_r     (bus_run)
    );

    // buffered master clock follows crystal only while gate is open
    assign mclk_nxt    = xtal_run & xtal_s2_r;
    assign xtal_en_nxt = xtal_run & xtal_s2_r & ~xtal_s3_r;

    // module run = enable and bus clock; registers stay untouched
    assign run_nxt = ctrl_en_r & {5{bus_run}};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_s1_r <= 1'b0;
            xtal_s2_r <= 1'b0;
            xtal_s3_r <= 1'b0;
        end else begin
            xtal_s1_r <= crystal_clock_in;
            xtal_s2_r <= xtal_s1_r;
            xtal_s3_r <= xtal_s2_r;
        end
    end

    // registers: reset only by presetn, never by gating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_r  <= CTRL_EN_RST;
            pmctl_r    <= PMCTL_RST;
            codec_pd_r <= 1'b0;
            cx_idx_r   <= CX_IDX_RST;
            cx_data_r  <= CX_DATA_RST;
            cx_valid_r <= 1'b0;
        end else begin
            ctrl_en_r  <= ctrl_en_nxt;
            pmctl_r    <= pmctl_nxt;
            codec_pd_r <= codec_pd_nxt;
            cx_idx_r   <= cx_idx_nxt;
            cx_data_r  <= cx_data_nxt;
            cx_valid_r <= cx_valid_nxt;
        end
    end

    // apb answer: ready raised in setup, so one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r  <= prdata_nxt;
            pready_r  <= setup_w;
            pslverr_r <= pslverr_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mclk_r    <= 1'b0;
            xtal_en_r <= 1'b0;
            run_r     <= 5'h00;
        end else begin
            mclk_r    <= mclk_nxt;
            xtal_en_r <= xtal_en_nxt;
            run_r     <= run_nxt;
        end
    end

    // outputs straight from flops
    assign prdata                    = prdata_r;
    assign pready                    = pready_r;
    assign pslverr                   = pslverr_r;
    assign buffered_master_clock_out = mclk_r;
    assign xtal_clk_en               = xtal_en_r;
    // modules with no enable bit follow the bus gate only
    assign core_clk_en               = bus_run;
    // bus interface and irq/select never lose their clock
    assign bus_if_clk_en             = presetn_q_r;
    assign joy_run                   = run_r[EN_JOY_BIT-EN_LO];
    assign uart_run                  = run_r[EN_UART_BIT-EN_LO];
    assign dac1_run                  = run_r[EN_DAC1_BIT-EN_LO];
    assign dac2_run                  = run_r[EN_DAC2_BIT-EN_LO];
    assign adc_run                   = run_r[EN_ADC_BIT-EN_LO];
    assign codec_wr_valid            = cx_valid_r;
    assign codec_wr_index            = cx_idx_r;
    assign codec_wr_data             = cx_data_r;

    // always-on enable for bus interface, high from first edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presetn_q_r <= 1'b0;
        end else begin
            presetn_q_r <= 1'b1;
        end
    end
endmodule // pcg_top
`default_nettype wire

// [verilog/pcg_pkg.sv]
// pcg_pkg: register map, field positions and reset values of the
// power and clock gating block.
// assumes a 32-bit apb3 slave clocked by pclk at 100 MHz.
package pcg_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;

    // register byte addresses
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_PMCTL      = 8'h08;
    localparam logic [7:0]  ADDR_STATUS     = 8'h0c;
    localparam logic [7:0]  ADDR_CODEC      = 8'h14;

    // main control: module enables
    localparam int          EN_JOY_BIT      = 6;
    localparam int          EN_UART_BIT     = 5;
    localparam int          EN_DAC1_BIT     = 4;
    localparam int          EN_DAC2_BIT     = 3;
    localparam int          EN_ADC_BIT      = 2;
    localparam int          EN_LO           = 2;
    localparam int          EN_HI           = 6;
    localparam logic [4:0]  CTRL_EN_RST     = 5'h00;

    // clock gate control
    localparam int          PM_BUS_RUN_BIT  = 0;
    localparam int          PM_XTAL_RUN_BIT = 1;
    localparam logic [1:0]  PMCTL_RST       = 2'h0;

    // status layout
    localparam int          ST_BUS_BIT      = 0;
    localparam int          ST_XTAL_BIT     = 1;
    localparam int          ST_CODEC_PD_BIT = 7;
    localparam int          ST_BUSY_BIT     = 8;

    // codec access word layout
    localparam int          CX_DATA_LO      = 0;
    localparam int          CX_DATA_HI      = 15;
    localparam int          CX_IDX_LO       = 16;
    localparam int          CX_IDX_HI       = 22;
    localparam logic [6:0]  CODEC_PD_INDEX  = 7'h16;
    localparam int          CODEC_PD_BIT    = 1;
    localparam logic [6:0]  CX_IDX_RST      = 7'h00;
    localparam logic [15:0] CX_DATA_RST     = 16'h0000;

    // nominal crystal rate in kHz, for reference by users
    localparam int          XTAL_KHZ        = 24576;
endpackage

// [verilog/pcg_gate_cell.sv]
// pcg_gate_cell: glitch-free run flag for one gated clock.
// assumes phase_low is a level on clk that is high while the gated
// clock is in its low phase.
`timescale 1ns/1ps
`default_nettype none
module pcg_gate_cell (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic run_req,
    input  wire logic phase_low,
    output var  logic run_r
);
    logic run_nxt;

    // only switch while the clock is low: no shortened pulse
    assign run_nxt = phase_low ? run_req : run_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_r <= 1'b0;
        end else begin
            run_r <= run_nxt;
        end
    end
endmodule // pcg_gate_cell
`default_nettype wire

// [tb/pcg_properties.sv]
// pcg_properties: port-level checks of the gating block.
// assumes binding into pcg_top; one clock, pclk.
`timescale 1ns/1ps
`default_nettype none
module pcg_props
    import pcg_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              crystal_clock_in,
    input wire logic              buffered_master_clock_out,
    input wire logic              xtal_clk_en,
    input wire logic              core_clk_en,
    input wire logic              bus_if_clk_en,
    input wire logic              joy_run,
    input wire logic              uart_run,
    input wire logic              dac1_run,
    input wire logic              dac2_run,
    input wire logic              adc_run,
    input wire logic              codec_wr_valid,
    input wire logic              codec_wr_ready,
    input wire logic [6:0]        codec_wr_index,
    input wire logic [15:0]       codec_wr_data
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic [4:0] runs = {joy_run, uart_run, dac1_run, dac2_run, adc_run};

    a_bus_if_on: assert property (
        $past(presetn) |-> bus_if_clk_en) else $error("bus if clock off");
    a_gate_idle: assert property (
        !$past(psel) && !$past(psel, 2) && !$past(psel, 3) && !$past(psel, 4)
        |-> $stable({runs, core_clk_en})) else $error("gating changed alone");
    a_gate_stops: assert property (
        !core_clk_en && !$past(core_clk_en) |-> runs == 5'h00)
        else $error("module runs while bus gate closed");
    a_sleep_start: assert property (
        !$past(presetn) |-> runs == 5'h00 && !core_clk_en && !xtal_clk_en
        && !buffered_master_clock_out) else $error("not asleep after reset");
    a_mclk_whole: assert property (
        $rose(buffered_master_clock_out) |=> buffered_master_clock_out)
        else $error("short master clock pulse");
    a_xtal_pulse: assert property (
        xtal_clk_en |=> !xtal_clk_en) else $error("crystal enable too long");
    a_xtal_follows: assert property (
        xtal_clk_en |-> ##[0:4] buffered_master_clock_out)
        else $error("master clock out not following crystal");
    a_codec_hold: assert property (
        codec_wr_valid && !codec_wr_ready |=> codec_wr_valid
        && $stable(codec_wr_index) && $stable(codec_wr_data))
        else $error("codec write not held");
    a_codec_take: assert property (
        psel && penable && pwrite && paddr == ADDR_CODEC && !codec_wr_valid
        |=> codec_wr_valid && codec_wr_index == $past(pwdata[22:16])
        && codec_wr_data == $past(pwdata[15:0]))
        else $error("codec write lost");
endmodule // pcg_props
bind pcg_top pcg_props u_props (.*);
`default_nettype wire

// [tb/pcg_codec_far.sv]
// pcg_codec_far: crystal source and codec write acceptor.
// assumes pclk drives the write handshake; the crystal runs free.
`timescale 1ns/1ps
`default_nettype none
module pcg_codec_far (
    input  wire logic       pclk,
    input  wire logic       codec_wr_valid,
    input  wire logic [1:0] lag,
    output var  logic       crystal_clock_in,
    output var  logic       codec_wr_ready
);
    logic [1:0] wait_r = 2'h0;
    initial begin
        crystal_clock_in = 1'b0;
        #3.1;
        forever #20.345 crystal_clock_in = ~crystal_clock_in;
    end
    // ready only after lag cycles of valid, so slow answers get exercised
    always @(posedge pclk) wait_r <= codec_wr_valid ? wait_r + 2'h1 : 2'h0;
    assign codec_wr_ready = codec_wr_valid && (wait_r >= lag);
endmodule // pcg_codec_far
`default_nettype wire

// [tb/testbench.sv]
// testbench: apb stimulus, response queue and checks for pcg_top.
// assumes pcg_codec_far as crystal source and codec.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pcg_pkg::*;
    typedef struct packed {logic full; logic err; logic [31:0] d;} pcg_exp_t;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [1:0]  lag = 2'h0;
    logic [31:0] d;
    wire logic [31:0] prdata;
    wire logic [15:0] codec_wr_data;
    wire logic [6:0]  codec_wr_index;
    wire logic pready, pslverr, crystal_clock_in, buffered_master_clock_out;
    wire logic xtal_clk_en, core_clk_en, bus_if_clk_en, codec_wr_valid;
    wire logic joy_run, uart_run, dac1_run, dac2_run, adc_run, codec_wr_ready;
    wire logic [4:0] runs = {joy_run, uart_run, dac1_run, dac2_run, adc_run};
    pcg_exp_t exp_q[$];
    int miscompares = 0;
    int compares = 0;
    int seed = 36;
    int n;
    int m;
    pcg_top DUT (.*);
    pcg_codec_far u_far (.*);
    always #5 pclk = ~pclk;

    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, input logic full,
                       input logic err, input logic [31:0] e);
        @(posedge pclk);
        exp_q.push_back({full, err, e});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tally_and_finish;
        if (miscompares == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // response side: oldest note against each answered transfer
    always @(posedge pclk) begin
        if (pready === 1'b1) begin : take
            pcg_exp_t e;
            e = exp_q.pop_front();
            chk("pslverr", {31'h0, e.err}, {31'h0, pslverr});
            if (e.full) chk("prdata", e.d, prdata);
        end
    end
    task automatic settle(input int c, input logic [31:0] e);
        repeat (c) @(posedge pclk);
        chk("runs", e, {25'h0, runs, 2'h0});
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1 chk("sleep", 0, {25'h0, runs, core_clk_en, xtal_clk_en});
        apb(0, ADDR_CTRL, 0, 1, 0, 0);
        apb(0, ADDR_PMCTL, 0, 1, 0, 0);
        apb(1, ADDR_CTRL, 32'h7c, 0, 0, 0);
        settle(4, 0);
        apb(1, ADDR_PMCTL, 1, 0, 0, 0);
        for (int i = 2; i <= 6; i++) begin
            apb(1, ADDR_CTRL, 32'h1 << i, 0, 0, 0);
            settle(4, 32'h1 << i);
            chk("core", 1, {31'h0, core_clk_en});
        end
        repeat (8) begin
            d = $random(seed);
            apb(1, ADDR_CTRL, d, 0, 0, 0);
            apb(1, ADDR_PMCTL, 0, 0, 0, 0);
            settle(4, 0);
            chk("bus if", 1, {31'h0, bus_if_clk_en});
            apb(0, ADDR_CTRL, 0, 1, 0, d & 32'h7c);
            apb(1, ADDR_PMCTL, 1, 0, 0, 0);
            settle(4, d & 32'h7c);
        end
        apb(1, ADDR_PMCTL, 3, 0, 0, 0);
        repeat (20) @(posedge pclk);
        n = 0;
        m = 0;
        repeat (200) begin
            @(posedge pclk);
            if (xtal_clk_en === 1'b1) n++;
            if (buffered_master_clock_out === 1'b1) m++;
        end
        chk("xtal pulses", 1, {31'h0, n >= 48 && n <= 50});
        chk("mclk high", 1, {31'h0, m >= 80 && m <= 120});
        apb(1, ADDR_PMCTL, 1, 0, 0, 0);
        repeat (10) @(posedge pclk);
        n = 0;
        repeat (100) begin
            @(posedge pclk);
            if (xtal_clk_en !== 1'b0) n++;
            if (buffered_master_clock_out !== 1'b0) n++;
        end
        chk("xtal stopped", 0, n);
        lag <= 2'h3;
        apb(1, ADDR_CODEC, 32'h0016fffd, 0, 0, 0);
        @(posedge pclk);
        chk("codec", 32'h8016fffd,
            {codec_wr_valid, 8'h0, codec_wr_index, codec_wr_data});
        apb(0, ADDR_CODEC, 0, 1, 0, 32'h0016fffd);
        apb(1, ADDR_CODEC, 32'h00050000, 0, 0, 0);
        repeat (8) @(posedge pclk);
        apb(0, ADDR_STATUS, 0, 1, 0, (d & 32'h7c) | 32'h81);
        lag <= 2'h0;
        apb(1, ADDR_CODEC, 32'h00160002, 0, 0, 0);
        repeat (8) @(posedge pclk);
        apb(0, ADDR_STATUS, 0, 1, 0, (d & 32'h7c) | 32'h01);
        apb(0, 8'h40, 0, 1, 1, 0);
        apb(1, ADDR_STATUS, 32'hffff, 0, 1, 0);
        apb(0, ADDR_PMCTL, 0, 1, 0, 1);
        repeat (3) @(posedge pclk);
        tally_and_finish();
    end
    initial begin
        #60000;
        miscompares++;
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
